/* verilog/link_init_sequencer.sv */
// module: i2c master that brings up the camera serial link
`timescale 1ns/10ps

// Functional notes
// - hub deserializer at 7-bit address 0x3d
// - first write 0x01 to hub 0x4c
// - write 0x5d to hub 0x58
// - write 0xe8 to hub 0x5c
// - write 0x80 to hub 0x5d
// - write 0x80 to hub 0x66
// - write 0x7c to hub 0x6d
// - write 0x01 to hub 0x32
// - write 0x03 to hub 0x33
// - write 0x03 to hub 0x21
// - write 0x80 to hub 0x20
// - then address serializer at alias 0x74
// - write 0x21 to serializer 0x06
// - write 0x2a to serializer 0x07
// - write 0x3c to serializer 0x0e
// - write 0x01 to 0x0d releases imager reset
// - imager at 0x40 only after both configured
// - power-down input low until supplies settle
module link_init_sequencer #(
  parameter int SETTLE_COUNT = link_init_pkg::SETTLE_CYCLES,
  parameter int QUARTER_COUNT = link_init_pkg::QUARTER_CYCLES
) (
  input wire logic clk, // 50 mhz system clock
  input wire logic reset, // synchronous, active high
  input wire link_init_pkg::sw_req_s sw_req, // software request
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic supplies_good, // pin: all rails in regulation
  output logic power_down_input, // serializer enable, low holds off
  input wire logic scl_in, // i2c clock pin level
  output logic scl_oe, // drives scl low when high
  input wire logic sda_in, // i2c data pin level
  output logic sda_oe, // drives sda low when high
  output logic link_ready // high once imager may be addressed
);
  import link_init_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] sda_sync_r;
  logic [1:0] scl_sync_r;
  logic [1:0] good_sync_r;

  always_ff @(posedge clk) begin
    sda_sync_r <= {sda_sync_r[0], sda_in};
    scl_sync_r <= {scl_sync_r[0], scl_in};
    good_sync_r <= {good_sync_r[0], supplies_good};
  end

  wire sda_s = sda_sync_r[1];
  wire scl_s = scl_sync_r[1];
  wire good_s = good_sync_r[1];

  // ************************************************************
  // state
  // ************************************************************
  seq_state_e state_r, state_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] byte_r, byte_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic scl_oe_r, scl_oe_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic power_r, power_nxt;
  logic power_en_r;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic link_ready_r, link_ready_nxt;

  // ************************************************************
  // software port decode
  // ************************************************************
  wire ctrl_hit = sw_req.wr && sw_req.addr == CTRL_OFFSET;
  wire start_req = ctrl_hit && sw_req.wdata[CTRL_START_BIT];
  wire busy = state_r != ST_IDLE && state_r != ST_DONE &&
              state_r != ST_FAIL;
  wire [31:0] status_word = {28'h0, power_r, fail_r, done_r, busy};
  wire [31:0] progress_word = {27'h0, idx_r};
  wire [31:0] read_mux = (sw_req.addr == CTRL_OFFSET) ?
                           {30'h0, power_en_r, 1'b0} :
                         (sw_req.addr == STATUS_OFFSET) ? status_word :
                         (sw_req.addr == PROGRESS_OFFSET) ? progress_word :
                         32'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      power_en_r <= 1'b0;
    end else if (ctrl_hit) begin
      power_en_r <= sw_req.wdata[CTRL_POWER_BIT];
    end
  end

  // ************************************************************
  // byte selection for the current write
  // ************************************************************
  cfg_write_s cur_w;
  assign cur_w = SEQ_TABLE[idx_r[3:0]];
  wire to_hub = idx_r < 5'(NUM_HUB_WRITES);
  // first ten go to the hub, the rest through the serializer alias
  wire [6:0] dev_addr = to_hub ? HUB_ADDR : SER_ALIAS_ADDR;
  wire [7:0] byte_sel = (byte_r == 2'd0) ? {dev_addr, 1'b0} :
                        (byte_r == 2'd1) ? cur_w.reg_addr : cur_w.value;
  wire last_write = idx_r == 5'(NUM_WRITES - 1);
  wire quarter_done = wait_r == 32'(QUARTER_COUNT - 1);
  // clock stretching: hold the high phase while a slave keeps scl low
  wire stretch = phase_r == 2'd2 && !scl_s;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    phase_nxt = phase_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    idx_nxt = idx_r;
    shift_nxt = shift_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    power_nxt = power_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    rdata_nxt = sw_req.rd ? read_mux : rdata_r;
    // dropping supplies or software disable pulls the serializer down
    if (!good_s || !power_en_r) begin
      power_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE, ST_DONE, ST_FAIL: begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        if (start_req) begin
          state_nxt = ST_SETTLE;
          wait_nxt = 32'h0;
          power_nxt = 1'b0;
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          idx_nxt = 5'h0;
        end
      end
      ST_SETTLE: begin
        // rails must stay good for the whole settle time
        if (!good_s || !power_en_r) begin
          wait_nxt = 32'h0;
        end else if (wait_r == 32'(SETTLE_COUNT - 1)) begin
          power_nxt = 1'b1;
          wait_nxt = 32'h0;
          state_nxt = ST_START;
          phase_nxt = 2'd0;
        end else begin
          wait_nxt = wait_r + 32'h1;
        end
      end
      ST_START: begin
        wait_nxt = quarter_done ? 32'h0 : wait_r + 32'h1;
        if (quarter_done) begin
          phase_nxt = phase_r + 2'd1;
          case (phase_r)
            2'd0: sda_oe_nxt = 1'b1;
            2'd1: scl_oe_nxt = 1'b1;
            default: begin
              byte_nxt = 2'd0;
              bit_nxt = 4'd0;
              shift_nxt = {dev_addr, 1'b0};
              phase_nxt = 2'd0;
              state_nxt = ST_BIT;
            end
          endcase
        end
      end
      ST_BIT, ST_ACK: begin
        wait_nxt = (quarter_done || stretch) ? 32'h0 : wait_r + 32'h1;
        if (quarter_done && !stretch) begin
          phase_nxt = phase_r + 2'd1;
          case (phase_r)
            2'd0: sda_oe_nxt = (state_r == ST_BIT) ? !shift_r[7] : 1'b0;
            2'd1: scl_oe_nxt = 1'b0;
            2'd2: begin
              if (state_r == ST_ACK && sda_s) begin
                fail_nxt = 1'b1;
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              if (state_r == ST_BIT) begin
                shift_nxt = {shift_r[6:0], 1'b0};
                bit_nxt = bit_r + 4'd1;
                if (bit_r == 4'd7) begin
                  state_nxt = ST_ACK;
                end
              end else if (fail_r) begin
                state_nxt = ST_STOP;
              end else if (byte_r == 2'd2) begin
                state_nxt = ST_STOP;
              end else begin
                byte_nxt = byte_r + 2'd1;
                bit_nxt = 4'd0;
                shift_nxt = (byte_r == 2'd0) ? cur_w.reg_addr : cur_w.value;
                state_nxt = ST_BIT;
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        wait_nxt = (quarter_done || stretch) ? 32'h0 : wait_r + 32'h1;
        if (quarter_done && !stretch) begin
          phase_nxt = phase_r + 2'd1;
          case (phase_r)
            2'd0: sda_oe_nxt = 1'b1;
            2'd1: scl_oe_nxt = 1'b0;
            2'd2: sda_oe_nxt = 1'b0;
            default: state_nxt = fail_r ? ST_FAIL : ST_NEXT;
          endcase
        end
      end
      ST_NEXT: begin
        // table order is the bring-up order, hub before serializer
        if (last_write) begin
          done_nxt = 1'b1;
          state_nxt = ST_DONE;
        end else begin
          idx_nxt = idx_r + 5'h1;
          phase_nxt = 2'd0;
          wait_nxt = 32'h0;
          state_nxt = ST_START;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    link_ready_nxt = done_nxt && power_nxt;
  end

  // one short block per flop keeps each reset value beside its register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_r <= 32'h0;
    end else begin
      wait_r <= wait_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_r <= 2'd0;
    end else begin
      phase_r <= phase_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_r <= 4'd0;
    end else begin
      bit_r <= bit_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      byte_r <= 2'd0;
    end else begin
      byte_r <= byte_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_r <= 5'h0;
    end else begin
      idx_r <= idx_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_r <= 8'h0;
    end else begin
      shift_r <= shift_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= scl_oe_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= sda_oe_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      power_r <= 1'b0;
    end else begin
      power_r <= power_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_r <= 1'b0;
    end else begin
      fail_r <= fail_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      link_ready_r <= 1'b0;
    end else begin
      link_ready_r <= link_ready_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata = rdata_r;
  assign power_down_input = power_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  // imager at IMAGER_ADDR is usable once done and powered; reset released write
  assign link_ready = link_ready_r;

endmodule : link_init_sequencer

/* verilog/link_init_pkg.sv */
// package: constants and types for the camera link init sequencer
package link_init_pkg;

  // ************************************************************
  // i2c addresses (7-bit)
  // ************************************************************
  localparam logic [6:0] HUB_ADDR = 7'h3d;
  localparam logic [6:0] SER_ALIAS_ADDR = 7'h74;
  localparam logic [6:0] IMAGER_ADDR = 7'h40;

  // ************************************************************
  // sequence table
  // ************************************************************
  localparam int NUM_WRITES = 14;
  localparam int NUM_HUB_WRITES = 10;

  typedef struct packed {
    logic [7:0] reg_addr;
    logic [7:0] value;
  } cfg_write_s;

  localparam cfg_write_s SEQ_TABLE [NUM_WRITES] = '{
    '{8'h4c, 8'h01}, '{8'h58, 8'h5d}, '{8'h5c, 8'he8}, '{8'h5d, 8'h80},
    '{8'h66, 8'h80}, '{8'h6d, 8'h7c}, '{8'h32, 8'h01}, '{8'h33, 8'h03},
    '{8'h21, 8'h03}, '{8'h20, 8'h80},
    '{8'h06, 8'h21}, '{8'h07, 8'h2a}, '{8'h0e, 8'h3c}, '{8'h0d, 8'h01}
  };

  // ************************************************************
  // software port map (byte addresses)
  // ************************************************************
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] PROGRESS_OFFSET = 4'h8;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_POWER_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_POWER_BIT = 3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QUARTER_CYCLES = CLK_HZ / (SCL_HZ * 4);
  localparam int SETTLE_MS = 10;
  localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETTLE, ST_START, ST_BIT, ST_ACK, ST_STOP, ST_NEXT,
    ST_DONE, ST_FAIL
  } seq_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sw_req_s;

endpackage : link_init_pkg

/* tb/link_dev_model.sv */
// model: hub deserializer and serializer seen as i2c write targets
`timescale 1ns/10ps
module link_dev_model (
  input wire logic scl, // i2c clock line level
  input wire logic sda, // i2c data line level
  input wire logic nak, // refuse every byte when high
  output logic sda_oe, // pulls sda low when high
  output logic img_rst_n // imager reset line, low holds reset
);
  logic [23:0] log_q[$];
  logic [23:0] fr;
  logic [7:0] sh;
  int bc;
  int nb;
  logic act;
  initial begin
    sda_oe = 0;
    img_rst_n = 0;
    act = 0;
  end
  always @(negedge sda) if (scl) begin
    bc = 0;
    nb = 0;
    act = 1;
  end
  // only complete three-byte writes are logged
  always @(posedge sda) if (scl && act) begin
    act = 0;
    if (nb == 3) begin
      log_q.push_back(fr);
      if (fr[23:8] == 16'he80d) img_rst_n = fr[0];
    end
  end
  always @(posedge scl) if (act && bc < 8) begin
    sh = {sh[6:0], sda};
    bc++;
  end
  always @(negedge scl) if (act) begin
    if (bc == 8) begin
      fr = {fr[15:0], sh};
      nb++;
      sda_oe = !nak && (nb != 1 || sh[7:1] inside {7'h3d, 7'h74});
      bc = 9;
    end else if (bc == 9) begin
      sda_oe = 0;
      bc = 0;
    end
  end
endmodule : link_dev_model

/* tb/link_init_sequencer_chk.sv */
// checker: port-level assertions for the link init sequencer
`timescale 1ns/10ps
module link_init_chk #(
  parameter int SETTLE_COUNT = link_init_pkg::SETTLE_CYCLES,
  parameter int QUARTER_COUNT = link_init_pkg::QUARTER_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic reset, // sync reset
  input wire link_init_pkg::sw_req_s sw_req, // software request
  input wire logic [31:0] rdata, // read data
  input wire logic supplies_good, // rails settled
  input wire logic power_down_input, // serializer enable
  input wire logic scl_in, // scl level
  input wire logic scl_oe, // scl pull
  input wire logic sda_in, // sda level
  input wire logic sda_oe, // sda pull
  input wire logic link_ready // imager reachable
);
  import link_init_pkg::*;
  localparam int START_WAIT = 2 * QUARTER_COUNT + 4;
  int good_cnt_r;
  // raw pin count; the design's synchronizer only adds cycles
  always_ff @(posedge clk) begin
    if (reset || !supplies_good) good_cnt_r <= 0;
    else good_cnt_r <= good_cnt_r + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_reset_quiet;
    disable iff (1'b0) reset |=> !power_down_input && !scl_oe && !sda_oe
      && !link_ready && rdata == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_power_settle;
    $rose(power_down_input) |-> good_cnt_r >= SETTLE_COUNT;
  endproperty
  a_power_settle: assert property (p_power_settle)
    else $error("power rose before supplies settled");
  property p_power_drop;
    !supplies_good [*5] |-> !power_down_input;
  endproperty
  a_power_drop: assert property (p_power_drop)
    else $error("power held without supplies");
  property p_status_power;
    sw_req.rd && sw_req.addr == STATUS_OFFSET
      |=> rdata[ST_POWER_BIT] == $past(power_down_input);
  endproperty
  a_status_power: assert property (p_status_power)
    else $error("status power bit wrong");
  property p_ready_power;
    link_ready |-> $past(power_down_input);
  endproperty
  a_ready_power: assert property (p_ready_power)
    else $error("ready without power");
  property p_ready_idle;
    link_ready |-> !scl_oe && !sda_oe;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("bus busy while ready");
  property p_start_cond;
    $rose(sda_oe) && !scl_oe |-> ##[1:START_WAIT] scl_oe;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("start not followed by clock");
  property p_scl_high;
    $fell(scl_oe) |-> !scl_oe [*4];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase too short");
  property p_sda_at_pull;
    $rose(scl_oe) |-> $stable(sda_oe);
  endproperty
  a_sda_at_pull: assert property (p_sda_at_pull)
    else $error("sda moved with scl edge");
endmodule : link_init_chk
bind link_init_sequencer link_init_chk #(
  .SETTLE_COUNT(SETTLE_COUNT), .QUARTER_COUNT(QUARTER_COUNT)
) u_link_init_chk (.clk(clk), .reset(reset), .sw_req(sw_req),
  .rdata(rdata), .supplies_good(supplies_good),
  .power_down_input(power_down_input), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_oe(sda_oe), .link_ready(link_ready));

/* tb/tb_top.sv */
// testbench: sequencer against a model of the link devices
`timescale 1ns/10ps
module tb_top;
  import link_init_pkg::*;
  localparam int SETTLE = 20;
  localparam logic [23:0] EXP_T [14] = '{
    24'h7a4c01, 24'h7a585d, 24'h7a5ce8, 24'h7a5d80, 24'h7a6680,
    24'h7a6d7c, 24'h7a3201, 24'h7a3303, 24'h7a2103, 24'h7a2080,
    24'he80621, 24'he8072a, 24'he80e3c, 24'he80d01};
  logic clk, reset, supplies_good, nak;
  sw_req_s sw_req;
  logic [31:0] rdata;
  logic power_down_input, scl_oe, sda_oe, dev_oe, link_ready, img_rst_n;
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || dev_oe);
  int n_mismatch;
  int num_checks;
  link_init_sequencer #(.SETTLE_COUNT(SETTLE), .QUARTER_COUNT(4))
  u_link_init_sequencer (.clk(clk), .reset(reset), .sw_req(sw_req),
    .rdata(rdata), .supplies_good(supplies_good),
    .power_down_input(power_down_input), .scl_in(scl), .scl_oe(scl_oe),
    .sda_in(sda), .sda_oe(sda_oe), .link_ready(link_ready));
  link_dev_model u_link_dev_model (.scl(scl), .sda(sda), .nak(nak),
    .sda_oe(dev_oe), .img_rst_n(img_rst_n));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [3:0] a, input logic [31:0] d,
                     input logic w, output logic [31:0] q);
    @(posedge clk);
    sw_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    sw_req <= '0;
    #1 q = rdata;
  endtask : bus
  // bounded poll until the flag is up and the stop has finished
  task automatic wait_bit(input int b, output logic [31:0] q);
    q = 0;
    for (int i = 0; i < 20000 && (q[b] !== 1'b1 || q[ST_BUSY_BIT] !== 1'b0);
         i++)
      bus(STATUS_OFFSET, 32'h0, 1'b0, q);
  endtask : wait_bit
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    logic [31:0] q;
    chk({power_down_input, scl_oe, sda_oe, link_ready}, 0, "pins");
    bus(STATUS_OFFSET, 32'h0, 1'b0, q);
    chk(q, 0, "status after reset");
    bus(4'hc, 32'h0, 1'b0, q);
    chk(q, 0, "unmapped read");
  endtask : t_reset
  task automatic t_power_and_run;
    logic [31:0] q;
    bus(CTRL_OFFSET, 32'h3, 1'b1, q);
    repeat (3 * SETTLE) @(negedge clk);
    chk(power_down_input, 0, "power without supplies");
    @(posedge clk);
    supplies_good <= 1;
    repeat (SETTLE) @(negedge clk);
    chk(power_down_input, 0, "power before settle");
    wait_bit(ST_DONE_BIT, q);
    chk(q[3:0], 4'ha, "status done");
    chk(u_link_dev_model.log_q.size(), 14, "write count");
    foreach (EXP_T[i])
      chk(u_link_dev_model.log_q[i], EXP_T[i], "write");
    chk({img_rst_n, link_ready}, 2'b11, "imager released");
    bus(PROGRESS_OFFSET, 32'h0, 1'b0, q);
    chk(q, 32'(NUM_WRITES - 1), "progress at end");
    bus(CTRL_OFFSET, 32'h0, 1'b0, q);
    chk(q, 32'h2, "control readback");
  endtask : t_power_and_run
  task automatic t_nak;
    logic [31:0] q;
    u_link_dev_model.log_q.delete();
    nak <= 1;
    bus(CTRL_OFFSET, 32'h3, 1'b1, q);
    wait_bit(ST_FAIL_BIT, q);
    chk(q[2:0], 3'h4, "status fail");
    repeat (50) @(negedge clk);
    chk(u_link_dev_model.log_q.size(), 0, "writes after refusal");
    chk({link_ready, scl_oe, sda_oe}, 0, "idle after refusal");
    nak <= 0;
  endtask : t_nak
  task automatic t_drop;
    @(posedge clk);
    supplies_good <= 0;
    repeat (8) @(negedge clk);
    chk(power_down_input, 0, "power after drop");
  endtask : t_drop
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    reset = 1;
    supplies_good = 0;
    nak = 0;
    sw_req = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    reset <= 0;
    @(negedge clk);
    t_reset();
    t_power_and_run();
    t_nak();
    t_drop();
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
